// ### shared/cffi_pkg.sv
`default_nettype none

package cffi_pkg;

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
localparam logic [7:0] REG_CTRL = 8'h00;
localparam logic [7:0] REG_INSTR = 8'h04;
localparam logic [7:0] REG_PC = 8'h08;
localparam logic [7:0] REG_SP = 8'h0c;
localparam logic [7:0] REG_CCR = 8'h10;
localparam logic [7:0] REG_OPA = 8'h14;
localparam logic [7:0] REG_COUNT = 8'h18;
localparam logic [7:0] REG_SRC = 8'h1c;
localparam logic [7:0] REG_DST = 8'h20;
localparam logic [7:0] REG_STATUS = 8'h24;
localparam logic [7:0] REG_RESULT = 8'h28;
localparam logic [7:0] REG_STATES = 8'h2c;
localparam logic [7:0] REG_MADDR = 8'h30;
localparam logic [7:0] REG_MDATA = 8'h34;

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
localparam int CTRL_GO = 0;
localparam int CCR_C = 0;
localparam int CCR_V = 1;
localparam int CCR_Z = 2;
localparam int CCR_N = 3;
localparam int CCR_H = 5;
localparam logic [15:0] PC_RESET = 16'h0000;
localparam logic [15:0] SP_RESET = 16'h0000;
localparam logic [7:0] CCR_RESET = 8'h80;

// ----------------------------------------
// States per cycle type, on-chip memory
// ----------------------------------------
localparam int ST_I = 2; // RQ17 RQ18
localparam int ST_J = 2;
localparam int ST_K = 2;
localparam int ST_L = 2;
localparam int ST_M = 2;
localparam int ST_N = 1; // RQ18
localparam int MOVE_BYTE_STATES = 2 * ST_L;

// ----------------------------------------
// First-byte operation codes
// ----------------------------------------
localparam logic [7:0] OPC_NOP = 8'h00;
localparam logic [7:0] OPC_SLEEP = 8'h01;
localparam logic [7:0] OPC_STF = 8'h02;
localparam logic [7:0] OPC_LDF_REG = 8'h03;
localparam logic [7:0] OPC_ORF = 8'h04;
localparam logic [7:0] OPC_XORF = 8'h05;
localparam logic [7:0] OPC_ANDF = 8'h06;
localparam logic [7:0] OPC_LDF_IMM = 8'h07;
localparam logic [7:0] OPC_ADDW = 8'h09;
localparam logic [7:0] OPC_DADJ = 8'h0f;
localparam logic [7:0] OPC_SUBW = 8'h19;
localparam logic [7:0] OPC_DIVU = 8'h51;
localparam logic [7:0] OPC_RETURN = 8'h54;
localparam logic [7:0] OPC_REL_CALL = 8'h55;
localparam logic [7:0] OPC_XRET = 8'h56;
localparam logic [7:0] OPC_REG_CALL = 8'h59;
localparam logic [7:0] OPC_ABS_CALL = 8'h5a;
localparam logic [7:0] OPC_IND_CALL = 8'h5b;
localparam logic [7:0] OPC_MOVE = 8'h7b;
localparam logic [3:0] OPC_ADDC_HI = 4'h9;
localparam logic [3:0] OPC_SUBB_HI = 4'hb;

// ----------------------------------------
// Types
// ----------------------------------------
typedef enum logic [4:0] {
    OP_ILL, OP_NOP, OP_REL_CALL, OP_REG_CALL, OP_ABS_CALL, OP_IND_CALL,
    OP_RETURN, OP_XRET, OP_SLEEP, OP_LDF_IMM, OP_LDF_REG, OP_STF, OP_ANDF,
    OP_ORF, OP_XORF, OP_MOVE, OP_ADDW, OP_SUBW, OP_ADDC, OP_SUBB, OP_DADJ,
    OP_DIVU
} cffi_op_t;

typedef enum logic [1:0] {S_IDLE, S_EXEC, S_MOVE} cffi_fsm_t;

typedef struct packed {
    logic [3:0] i, j, k, l, m, n;
} cffi_cycles_t;

localparam cffi_cycles_t CYC_SHORT = '{4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
localparam cffi_cycles_t CYC_CALL = '{4'h2, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0};
localparam cffi_cycles_t CYC_CALL_ABS = '{4'h2, 4'h0, 4'h1, 4'h0, 4'h0, 4'h2};
localparam cffi_cycles_t CYC_CALL_IND = '{4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
localparam cffi_cycles_t CYC_RET = '{4'h2, 4'h0, 4'h1, 4'h0, 4'h0, 4'h2};
localparam cffi_cycles_t CYC_XRET = '{4'h2, 4'h0, 4'h2, 4'h0, 4'h0, 4'h2};
localparam cffi_cycles_t CYC_MOVE = '{4'h4, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
localparam cffi_cycles_t CYC_DIV = '{4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'hc};

typedef struct packed {
    cffi_fsm_t fsm;
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
    logic rdy;
    logic resp;
    logic busy;
    logic sleep;
    logic ill;
    logic [31:0] instr;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [7:0] condition_code_register;
    logic [15:0] opa;
    logic [15:0] result;
    logic [7:0] cnt;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] maddr;
    logic [11:0] states;
    logic [11:0] tick;
    logic [3:0] sub;
} cffi_state_t;

localparam cffi_state_t STATE_RESET = '{fsm: S_IDLE, rdy: 1'b1, pc: PC_RESET,
    sp: SP_RESET, condition_code_register: CCR_RESET, default: '0};

function automatic logic [11:0] cffi_states(input cffi_cycles_t c);
    return 12'(c.i * ST_I + c.j * ST_J + c.k * ST_K + c.l * ST_L + c.m * ST_M + c.n * ST_N);
endfunction

endpackage

`default_nettype wire

// ### rtl/cffi_core.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// RQ1: Relative call pushes return PC at SP-2, adds signed displacement; 6 states.
// RQ2: Register call pushes return PC, jumps to 16-bit register; 6 states.
// RQ3: Absolute and memory-indirect calls push PC, load new PC; 8 states.
// RQ4: Return pops PC, SP plus two, flags kept; 8 states.
// RQ5: Exception return pops flags then PC, SP plus four; 10 states.
// RQ6: Sleep enters power-down, flags kept; 2 states.
// RQ7: Flag load, and, or, xor write all flags; store keeps them; 2 states.
// RQ8: Block move copies bytes, bumps pointers, counts down; nothing when count zero.
// RQ9: Block move takes four states per byte plus eight.
// RQ10: Word add and subtract set half-carry from bit 11.
// RQ11: Carry-chained add and subtract keep zero on zero result, else clear.
// RQ12: Decimal adjust sets carry when the adjustment carries.
// RQ13: Divide sets negative from divisor sign, zero when divisor zero.
// RQ14: Operation decoded from first byte, bits 15 to 8.
// RQ15: Shared first bytes split by bit 7 of the word.
// RQ16: Total states is sum of cycle counts times states per type.
// RQ17: State counts assume on-chip instruction and operands.
// RQ18: Internal cycle one state, on-chip fetch two states.
// RQ19: Stack pointer stays even so stacked words are aligned.
module cffi_core
    import cffi_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Core status
    output logic busy,
    output logic sleeping
);

cffi_state_t s, n;
logic [7:0] mem [2**MEM_AW];
logic we0, we1;
logic [15:0] wa0, wa1;
logic [7:0] wd0, wd1;
cffi_op_t op;
cffi_cycles_t cyc;
logic go, sel;
logic [15:0] a, b, ret, tgt, nsp;

function automatic logic [7:0] rd(input logic [15:0] ad);
    return mem[ad[MEM_AW-1:0]];
endfunction

function automatic cffi_op_t cffi_decode(input logic [15:0] w);
    cffi_op_t o;
    o = OP_ILL;
    if (w[15:12] == OPC_ADDC_HI) begin
        o = OP_ADDC;
    end else if (w[15:12] == OPC_SUBB_HI) begin
        o = OP_SUBB;
    end else begin
        case (w[15:8]) // RQ14
            OPC_NOP: o = OP_NOP;
            OPC_SLEEP: if (w[7]) o = OP_SLEEP; // RQ15
            OPC_MOVE: if (!w[7]) o = OP_MOVE; // RQ15
            OPC_STF: o = OP_STF;
            OPC_LDF_REG: o = OP_LDF_REG;
            OPC_ORF: o = OP_ORF;
            OPC_XORF: o = OP_XORF;
            OPC_ANDF: o = OP_ANDF;
            OPC_LDF_IMM: o = OP_LDF_IMM;
            OPC_ADDW: o = OP_ADDW;
            OPC_DADJ: o = OP_DADJ;
            OPC_SUBW: o = OP_SUBW;
            OPC_DIVU: o = OP_DIVU;
            OPC_RETURN: o = OP_RETURN;
            OPC_REL_CALL: o = OP_REL_CALL;
            OPC_XRET: o = OP_XRET;
            OPC_REG_CALL: o = OP_REG_CALL;
            OPC_ABS_CALL: o = OP_ABS_CALL;
            OPC_IND_CALL: o = OP_IND_CALL;
            default: o = OP_ILL;
        endcase
    end
    return o;
endfunction

assign sel = hsel & htrans[1] & hready;
assign op = cffi_decode(s.instr[15:0]);
assign go = s.wr_pend & (s.addr == REG_CTRL) & hwdata[CTRL_GO] & (s.fsm == S_IDLE);
assign a = s.opa;
assign b = s.instr[31:16];
assign ret = (op == OP_ABS_CALL || op == OP_MOVE) ? s.pc + 16'h0004 : s.pc + 16'h0002;
assign tgt = s.pc + 16'h0002 + {{8{s.instr[7]}}, s.instr[7:0]};
assign nsp = s.sp - 16'h0002;

// ----------------------------------------
// Cycle mix per operation
// ----------------------------------------
always_comb begin
    case (op)
        OP_REL_CALL, OP_REG_CALL: cyc = CYC_CALL;
        OP_ABS_CALL: cyc = CYC_CALL_ABS;
        OP_IND_CALL: cyc = CYC_CALL_IND;
        OP_RETURN: cyc = CYC_RET;
        OP_XRET: cyc = CYC_XRET;
        OP_MOVE: cyc = CYC_MOVE;
        OP_DIVU: cyc = CYC_DIV;
        default: cyc = CYC_SHORT;
    endcase
end

// ----------------------------------------
// Next state
// ----------------------------------------
always_comb begin
    logic [31:0] rm;
    logic [7:0] f;
    logic [16:0] sum;
    logic [4:0] hs;
    logic [12:0] hw;
    logic lo, hi;
    rm = '0;
    f = s.condition_code_register;
    sum = '0;
    hs = '0;
    hw = '0;
    lo = 1'b0;
    hi = 1'b0;
    n = s;
    we0 = 1'b0;
    wa0 = '0;
    wd0 = '0;
    we1 = 1'b0;
    wa1 = '0;
    wd1 = '0;
    n.rdy = 1'b1;
    n.resp = 1'b0;
    n.wr_pend = sel & hwrite;
    if (sel) begin
        n.addr = haddr[7:0];
    end
    if (haddr[7:0] == REG_CTRL) rm = '0;
    else if (haddr[7:0] == REG_INSTR) rm = s.instr;
    else if (haddr[7:0] == REG_PC) rm = {16'h0000, s.pc};
    else if (haddr[7:0] == REG_SP) rm = {16'h0000, s.sp};
    else if (haddr[7:0] == REG_CCR) rm = {24'h000000, s.condition_code_register};
    else if (haddr[7:0] == REG_OPA) rm = {16'h0000, s.opa};
    else if (haddr[7:0] == REG_COUNT) rm = {24'h000000, s.cnt};
    else if (haddr[7:0] == REG_SRC) rm = {16'h0000, s.src};
    else if (haddr[7:0] == REG_DST) rm = {16'h0000, s.dst};
    else if (haddr[7:0] == REG_STATUS) rm = {29'h00000000, s.ill, s.sleep, s.busy};
    else if (haddr[7:0] == REG_RESULT) rm = {16'h0000, s.result};
    else if (haddr[7:0] == REG_STATES) rm = {20'h00000, s.states};
    else if (haddr[7:0] == REG_MADDR) rm = {16'h0000, s.maddr};
    else if (haddr[7:0] == REG_MDATA) rm = {24'h000000, rd(s.maddr)};
    if (sel && !hwrite) begin
        n.rdata = rm;
    end
    if (s.wr_pend && s.fsm == S_IDLE) begin
        if (s.addr == REG_INSTR) n.instr = hwdata;
        else if (s.addr == REG_PC) n.pc = hwdata[15:0];
        else if (s.addr == REG_SP) n.sp = {hwdata[15:1], 1'b0}; // RQ19
        else if (s.addr == REG_CCR) n.condition_code_register = hwdata[7:0];
        else if (s.addr == REG_OPA) n.opa = hwdata[15:0];
        else if (s.addr == REG_COUNT) n.cnt = hwdata[7:0];
        else if (s.addr == REG_SRC) n.src = hwdata[15:0];
        else if (s.addr == REG_DST) n.dst = hwdata[15:0];
        else if (s.addr == REG_MADDR) n.maddr = hwdata[15:0];
        else if (s.addr == REG_MDATA) begin
            we0 = 1'b1;
            wa0 = s.maddr;
            wd0 = hwdata[7:0];
        end
    end
    case (s.fsm)
        S_IDLE: begin
            if (go) begin
                n.fsm = S_EXEC;
                n.sleep = 1'b0;
                n.ill = (op == OP_ILL);
                n.tick = cffi_states(cyc) - 12'h001; // RQ16 RQ17 RQ18
                n.states = cffi_states(cyc) + 12'(s.cnt) * 12'(MOVE_BYTE_STATES); // RQ9
                n.pc = s.pc + 16'h0002;
                if (op == OP_REL_CALL || op == OP_REG_CALL ||
                    op == OP_ABS_CALL || op == OP_IND_CALL) begin
                    n.sp = nsp;
                    we0 = 1'b1;
                    wa0 = nsp;
                    wd0 = ret[15:8];
                    we1 = 1'b1;
                    wa1 = nsp + 16'h0001;
                    wd1 = ret[7:0];
                end
                // Per-byte states belong to block move only
                if (op != OP_MOVE) begin
                    n.states = cffi_states(cyc);
                end
                case (op)
                    OP_REL_CALL: n.pc = tgt; // RQ1
                    OP_REG_CALL: n.pc = a; // RQ2
                    OP_ABS_CALL: n.pc = b; // RQ3
                    OP_IND_CALL: n.pc = {rd({8'h00, s.instr[7:0]}),
                        rd({8'h00, s.instr[7:0]} + 16'h0001)}; // RQ3
                    OP_RETURN: begin
                        n.pc = {rd(s.sp), rd(s.sp + 16'h0001)}; // RQ4
                        n.sp = s.sp + 16'h0002;
                    end
                    OP_XRET: begin
                        f = rd(s.sp); // RQ5
                        n.pc = {rd(s.sp + 16'h0002), rd(s.sp + 16'h0003)};
                        n.sp = s.sp + 16'h0004;
                    end
                    OP_SLEEP: n.sleep = 1'b1; // RQ6
                    OP_LDF_IMM: f = s.instr[7:0]; // RQ7
                    OP_LDF_REG: f = a[7:0];
                    OP_STF: n.result = {8'h00, s.condition_code_register};
                    OP_ANDF: f = s.condition_code_register & s.instr[7:0];
                    OP_ORF: f = s.condition_code_register | s.instr[7:0];
                    OP_XORF: f = s.condition_code_register ^ s.instr[7:0];
                    OP_MOVE: n.pc = ret;
                    OP_ADDW, OP_SUBW: begin
                        if (op == OP_ADDW) begin
                            sum = {1'b0, a} + {1'b0, b};
                            hw = {1'b0, a[11:0]} + {1'b0, b[11:0]};
                            f[CCR_V] = (a[15] == b[15]) & (sum[15] != a[15]);
                        end else begin
                            sum = {1'b0, a} - {1'b0, b};
                            hw = {1'b0, a[11:0]} - {1'b0, b[11:0]};
                            f[CCR_V] = (a[15] != b[15]) & (sum[15] != a[15]);
                        end
                        f[CCR_H] = hw[12]; // RQ10
                        f[CCR_N] = sum[15];
                        f[CCR_Z] = (sum[15:0] == 16'h0000);
                        f[CCR_C] = sum[16];
                        n.result = sum[15:0];
                    end
                    OP_ADDC, OP_SUBB: begin
                        if (op == OP_ADDC) begin
                            sum = 17'(a[7:0]) + 17'(s.instr[7:0]) + 17'(s.condition_code_register[CCR_C]);
                            hs = 5'(a[3:0]) + 5'(s.instr[3:0]) + 5'(s.condition_code_register[CCR_C]);
                            f[CCR_V] = (a[7] == s.instr[7]) & (sum[7] != a[7]);
                        end else begin
                            sum = 17'(a[7:0]) - 17'(s.instr[7:0]) - 17'(s.condition_code_register[CCR_C]);
                            hs = 5'(a[3:0]) - 5'(s.instr[3:0]) - 5'(s.condition_code_register[CCR_C]);
                            f[CCR_V] = (a[7] != s.instr[7]) & (sum[7] != a[7]);
                        end
                        f[CCR_H] = hs[4];
                        f[CCR_N] = sum[7];
                        f[CCR_Z] = s.condition_code_register[CCR_Z] & (sum[7:0] == 8'h00); // RQ11
                        f[CCR_C] = sum[8];
                        n.result = {8'h00, sum[7:0]};
                    end
                    OP_DADJ: begin
                        lo = (a[3:0] > 4'h9) | s.condition_code_register[CCR_H];
                        hi = (a[7:0] > 8'h99) | s.condition_code_register[CCR_C];
                        sum = 17'(a[7:0]) + (hi ? 17'h00060 : 17'h00000) +
                            (lo ? 17'h00006 : 17'h00000);
                        f[CCR_C] = hi | sum[8]; // RQ12
                        f[CCR_N] = sum[7];
                        f[CCR_Z] = (sum[7:0] == 8'h00);
                        n.result = {8'h00, sum[7:0]};
                    end
                    OP_DIVU: begin
                        f[CCR_N] = b[7]; // RQ13
                        f[CCR_Z] = (b[7:0] == 8'h00);
                        if (b[7:0] != 8'h00) begin
                            n.result = {8'(a % {8'h00, b[7:0]}), 8'(a / {8'h00, b[7:0]})};
                        end
                    end
                    default: n.pc = s.pc + 16'h0002;
                endcase
                n.condition_code_register = f;
            end
        end
        S_EXEC: begin
            if (s.tick != 12'h000) begin
                n.tick = s.tick - 12'h001;
            end else if (op == OP_MOVE && s.cnt != 8'h00) begin // RQ8
                n.fsm = S_MOVE;
                n.sub = 4'(MOVE_BYTE_STATES - 1);
            end else begin
                n.fsm = S_IDLE;
            end
        end
        S_MOVE: begin
            if (s.sub != 4'h0) begin
                n.sub = s.sub - 4'h1;
            end else begin
                we0 = 1'b1; // RQ8
                wa0 = s.dst;
                wd0 = rd(s.src);
                n.src = s.src + 16'h0001;
                n.dst = s.dst + 16'h0001;
                n.cnt = s.cnt - 8'h01;
                if (s.cnt == 8'h01) begin
                    n.fsm = S_IDLE;
                end else begin
                    n.sub = 4'(MOVE_BYTE_STATES - 1); // RQ9
                end
            end
        end
        default: n.fsm = S_IDLE;
    endcase
    n.busy = (n.fsm != S_IDLE);
end

always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        s <= STATE_RESET;
    end else begin
        s <= n;
    end
end

always_ff @(posedge hclk) begin
    if (we0) begin
        mem[wa0[MEM_AW-1:0]] <= wd0;
    end
    if (we1) begin
        mem[wa1[MEM_AW-1:0]] <= wd1;
    end
end

assign hreadyout = s.rdy;
assign hresp = s.resp;
assign hrdata = s.rdata;
assign busy = s.busy;
assign sleeping = s.sleep;

// ----------------------------------------
// Checks
// ----------------------------------------
logic [11:0] run_q;
always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        run_q <= '0;
    end else if (go) begin
        run_q <= '0;
    end else if (s.busy) begin
        run_q <= run_q + 12'h001;
    end
end

default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);

sequence two_st;
    s.busy [*2] ##1 !s.busy;
endsequence
sequence six_st;
    s.busy [*6] ##1 !s.busy;
endsequence

AST_STATES: assert property ($fell(s.busy) |-> run_q == s.states) // RQ16 RQ9
    else $error("busy length differs from state count");
AST_REL_CALL: assert property (go && op == OP_REL_CALL |=> // RQ1
    s.sp == $past(nsp) && s.pc == $past(tgt) ##0 six_st)
    else $error("relative call wrong");
AST_REG_CALL: assert property (go && op == OP_REG_CALL |=> // RQ2
    s.pc == $past(s.opa) && s.sp == $past(nsp) ##0 six_st)
    else $error("register call wrong");
AST_ABS_CALL: assert property (go && op == OP_ABS_CALL |=> // RQ3
    s.pc == $past(b) ##0 s.busy [*8] ##1 !s.busy)
    else $error("absolute call wrong");
AST_RETURN: assert property (go && op == OP_RETURN |=> // RQ4
    s.sp == $past(s.sp) + 16'h0002 && $stable(s.condition_code_register))
    else $error("return wrong");
AST_XRET: assert property (go && op == OP_XRET |=> // RQ5
    s.sp == $past(s.sp) + 16'h0004 ##0 s.busy [*8] ##1 s.busy ##1 s.busy ##1 !s.busy)
    else $error("exception return wrong");
AST_SLEEP: assert property (go && op == OP_SLEEP |=> // RQ6
    s.sleep && $stable(s.condition_code_register) ##0 two_st)
    else $error("sleep wrong");
AST_FLAG_TIME: assert property (go && op inside {OP_LDF_IMM, OP_LDF_REG, OP_STF, // RQ7
    OP_ANDF, OP_ORF, OP_XORF} |=> two_st)
    else $error("flag operation not two states");
AST_MOVE_ZERO: assert property (go && op == OP_MOVE && s.cnt == 8'h00 |=> // RQ8
    ($stable(s.dst) && s.busy) [*8] ##1 !s.busy)
    else $error("empty block move not idle");
AST_CARRY_Z: assert property (go && op inside {OP_ADDC, OP_SUBB} && !s.condition_code_register[CCR_Z] |=> // RQ11
    !s.condition_code_register[CCR_Z])
    else $error("zero flag set by chained op");
AST_ALIGN: assert property (!s.sp[0]) // RQ19
    else $error("stack pointer odd");

endmodule
`default_nettype wire

// ### test/cffi_host.sv
`timescale 1ns/1ns
`default_nettype none

module cffi_host (
    // Clock
    input wire logic hclk,
    // AHB-Lite master side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // Single word transfer, entered just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
endmodule

`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import cffi_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, busy, sleeping;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int n_fail = 0;
    int total_checks = 0;

    always #5 hclk = ~hclk;

    cffi_core #(.MEM_AW(8)) cffi_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .busy(busy), .sleeping(sleeping));

    cffi_host cffi_host_i (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata));

    // ----
    // Helpers
    // ----
    task automatic stop_test;
        if (n_fail == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        cffi_host_i.xfer(a, 1'b1, d, q);
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        cffi_host_i.xfer(a, 1'b0, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic fl(input int b, input logic e);
        logic [31:0] q;
        cffi_host_i.xfer(REG_CCR, 1'b0, 32'h0, q);
        chk("flag", {31'h0, e}, {31'h0, q[b]});
    endtask

    task automatic mput(input logic [7:0] a, input logic [7:0] d);
        wr(REG_MADDR, {24'h0, a});
        wr(REG_MDATA, {24'h0, d});
    endtask

    task automatic mchk(input logic [7:0] a, input logic [7:0] e);
        wr(REG_MADDR, {24'h0, a});
        rc("mem", REG_MDATA, {24'h0, e});
    endtask

    // Start one instruction, measure busy span
    task automatic run(input logic [31:0] ins, input int st);
        int n;
        n = 0;
        wr(REG_INSTR, ins);
        wr(REG_CTRL, 32'h1);
        do begin
            @(posedge hclk);
            n++;
        end while (busy === 1'b1 && n < 2000);
        chk("busy_len", 32'(st), 32'(n - 1));
        rc("states", REG_STATES, 32'(st));
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_calls;
        rc("ccr_rst", REG_CCR, 32'h80);
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("hready", 32'h1, {31'h0, hreadyout});
        rc("unmapped", 8'hfc, 32'h0);
        wr(REG_SP, 32'h100);
        wr(REG_PC, 32'h10);
        run(32'h55fe, 6);
        rc("pc", REG_PC, 32'h10);
        rc("sp", REG_SP, 32'hfe);
        mchk(8'hff, 8'h12);
        run(32'h5400, 8);
        rc("pc", REG_PC, 32'h12);
        rc("sp", REG_SP, 32'h100);
        rc("ccr", REG_CCR, 32'h80);
        wr(REG_OPA, 32'habc);
        run(32'h5900, 6);
        rc("pc", REG_PC, 32'habc);
        mchk(8'hff, 8'h14);
        run(32'h12345a00, 8);
        rc("pc", REG_PC, 32'h1234);
        mchk(8'hfc, 8'h0a);
        mchk(8'hfd, 8'hc0);
        mput(8'h80, 8'h56);
        mput(8'h81, 8'h78);
        run(32'h5b80, 8);
        rc("pc", REG_PC, 32'h5678);
        rc("sp", REG_SP, 32'hfa);
        mput(8'h40, 8'h8b);
        mput(8'h42, 8'h12);
        mput(8'h43, 8'h34);
        wr(REG_SP, 32'h40);
        run(32'h5600, 10);
        rc("ccr", REG_CCR, 32'h8b);
        rc("pc", REG_PC, 32'h1234);
        rc("sp", REG_SP, 32'h44);
    endtask

    task automatic t_flags;
        logic [15:0] ins [5] = '{16'h0700, 16'h0485, 16'h060f, 16'h05ff, 16'h0300};
        logic [7:0] ex [5] = '{8'h00, 8'h85, 8'h05, 8'hfa, 8'h33};
        wr(REG_OPA, 32'h33);
        for (int i = 0; i < 5; i++) begin
            run({16'h0, ins[i]}, 2);
            rc("ccr", REG_CCR, {24'h0, ex[i]});
        end
        run(32'h0200, 2);
        rc("stored", REG_RESULT, 32'h33);
        run(32'h0180, 2);
        chk("sleeping", 32'h1, {31'h0, sleeping});
        rc("ccr", REG_CCR, 32'h33);
        run(32'h0100, 2);
        rc("status", REG_STATUS, 32'h4);
    endtask

    task automatic t_move;
        for (int i = 0; i < 3; i++) mput(8'(8'h10 + i), 8'(8'ha1 + 8'h11 * i));
        wr(REG_COUNT, 32'h3);
        wr(REG_SRC, 32'h10);
        wr(REG_DST, 32'h20);
        run(32'h7b00, 20);
        rc("src", REG_SRC, 32'h13);
        rc("dst", REG_DST, 32'h23);
        rc("count", REG_COUNT, 32'h0);
        for (int i = 0; i < 3; i++) mchk(8'(8'h20 + i), 8'(8'ha1 + 8'h11 * i));
        run(32'h7b00, 8);
        rc("src", REG_SRC, 32'h13);
    endtask

    task automatic t_alu;
        wr(REG_OPA, 32'h800);
        run(32'h08000900, 2);
        fl(CCR_H, 1'b1);
        wr(REG_OPA, 32'h100);
        run(32'h01000900, 2);
        fl(CCR_H, 1'b0);
        run(32'h0704, 2);
        wr(REG_OPA, 32'h0);
        run(32'h9000, 2);
        fl(CCR_Z, 1'b1);
        run(32'h9001, 2);
        fl(CCR_Z, 1'b0);
        run(32'h9000, 2);
        fl(CCR_Z, 1'b0);
        run(32'h0700, 2);
        wr(REG_OPA, 32'h9a);
        run(32'h0f00, 2);
        fl(CCR_C, 1'b1);
        run(32'h5100, 14);
        fl(CCR_Z, 1'b1);
        run(32'h00805100, 14);
        fl(CCR_N, 1'b1);
        fl(CCR_Z, 1'b0);
    endtask

    // ----
    // Main sequence and watchdog
    // ----
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_calls;
        t_flags;
        t_move;
        t_alu;
        stop_test;
    end

    initial begin
        #200000;
        n_fail++;
        stop_test;
    end
endmodule

`default_nettype wire
